/* File: src/pcs_pkg.sv */
package pcs_pkg;
   localparam int PCS_PC_W        = 10;
   localparam int PCS_INSN_W      = 12;
   localparam int PCS_DATA_W      = 8;
   localparam int PCS_JUMP_LSB    = 0;
   localparam int PCS_JUMP_MSB    = 8;
   localparam int PCS_PAGE_BIT    = 5;
   localparam int PCS_PC_PAGE_POS = 9;
   localparam int PCS_PC_B8_POS   = 8;
   localparam logic [9:0] PCS_PC_RESET = 10'h3ff;
   localparam logic [7:0] PCS_LOW_RESET = 8'hff;
   localparam logic [7:0] PCS_STATUS_RESET = 8'h00;
   localparam logic [9:0] PCS_STACK_RESET = 10'h000;
   localparam int PCS_BRANCH_CYCLES = 2;

   typedef enum logic [4:0] {
      PCS_OP_NONE  = 5'h01,
      PCS_OP_JUMP  = 5'h02,
      PCS_OP_CALL  = 5'h04,
      PCS_OP_RET   = 5'h08,
      PCS_OP_LOWWR = 5'h10
   } pcs_op_t;

   typedef enum logic [1:0] {
      PCS_ST_RUN   = 2'h1,
      PCS_ST_FLUSH = 2'h2
   } pcs_state_t;
endpackage

/* File: src/pcs_stack_if.sv */
`timescale 1ns/1ps
interface pcs_stack_if;
   logic       push;
   logic       pop;
   logic [9:0] push_data;
   logic [9:0] top;
   modport core (output push, output pop, output push_data, input top);
   modport mem  (input push, input pop, input push_data, output top);
endinterface

/* File: src/pcs_return_stack.sv */
`timescale 1ns/1ps
module pcs_return_stack
   import pcs_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  srst,
   pcs_stack_if.mem   port
);
   typedef struct packed {
      logic [9:0] level1;
      logic [9:0] level2;
   } pcs_stack_state_t;

   pcs_stack_state_t state;
   pcs_stack_state_t next_state;

   always_comb begin
      next_state = state;
      if (port.push) begin
         next_state.level2 = state.level1;
         next_state.level1 = port.push_data;
      end else if (port.pop) begin
         next_state.level1 = state.level2;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state <= '{level1: PCS_STACK_RESET, level2: PCS_STACK_RESET};
      end else begin
         state <= next_state;
      end
   end

   assign port.top = state.level1;
endmodule

/* File: src/pcs_sequencer.sv */
`timescale 1ns/1ps
module pcs_sequencer
   import pcs_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    srst,
   input  wire logic [PCS_INSN_W-1:0]   insn,
   input  wire pcs_op_t                 op,
   input  wire logic [PCS_DATA_W-1:0]   low_write_data,
   input  wire logic                    status_write,
   input  wire logic [PCS_DATA_W-1:0]   status_write_data,
   output logic      [PCS_PC_W-1:0]     fetch_addr,
   output logic      [PCS_DATA_W-1:0]   counter_low_byte,
   output logic      [PCS_DATA_W-1:0]   status_page_bits,
   output logic                         flush
);
   typedef struct packed {
      logic [PCS_PC_W-1:0]   pc;
      logic [PCS_DATA_W-1:0] status;
      pcs_state_t            st;
   } pcs_seq_state_t;

   // Counter, status copy and branch phase, registered together
   pcs_seq_state_t state;
   pcs_seq_state_t next_state;

   // Two-level return stack behind calls and returns
   pcs_stack_if    stack ();

   // Per-cycle decode shared by the next-state logic
   logic                  page_bit;
   logic                  in_flush;
   logic                  op_taken;
   logic [PCS_PC_W-1:0]   incr_pc;
   logic [PCS_PC_W-1:0]   jump_target;
   logic [PCS_PC_W-1:0]   call_target;
   logic [PCS_PC_W-1:0]   low_target;
   logic [PCS_PC_W-1:0]   return_target;

   // Plain sequential step; the top word rolls over to zero
   function automatic logic [PCS_PC_W-1:0] pcs_incr(input logic [PCS_PC_W-1:0] v);
      return PCS_PC_W'(v + 1'b1);
   endfunction

   // Jump keeps its whole nine-bit target below the page bit
   function automatic logic [PCS_PC_W-1:0] pcs_jump_load(input logic page,
                                                        input logic [PCS_JUMP_MSB:PCS_JUMP_LSB] target);
      return {page, target};
   endfunction

   // Bit eight forced low, so these loads reach only the first half page
   function automatic logic [PCS_PC_W-1:0] pcs_low_load(input logic page,
                                                       input logic [PCS_DATA_W-1:0] low);
      return {page, 1'b0, low};
   endfunction

   function automatic logic pcs_page(input logic [PCS_DATA_W-1:0] status);
      return status[PCS_PAGE_BIT];
   endfunction

   // Every operation other than none changes program flow
   function automatic logic pcs_is_branch(input pcs_op_t o);
      return (o == PCS_OP_JUMP) || (o == PCS_OP_CALL) || (o == PCS_OP_RET) || (o == PCS_OP_LOWWR);
   endfunction

   pcs_return_stack u_stack (
      .clock (clock),
      .srst  (srst),
      .port  (stack)
   );

   assign page_bit      = pcs_page(state.status);
   assign in_flush      = (state.st == PCS_ST_FLUSH);
   assign op_taken      = !in_flush && pcs_is_branch(op);
   assign incr_pc       = pcs_incr(state.pc);
   assign jump_target   = pcs_jump_load(page_bit, insn[PCS_JUMP_MSB:PCS_JUMP_LSB]);
   assign call_target   = pcs_low_load(page_bit, insn[PCS_DATA_W-1:0]);
   assign low_target    = pcs_low_load(page_bit, low_write_data);
   assign return_target = stack.top;

   always_comb begin
      stack.push      = 1'b0;
      stack.pop       = 1'b0;
      stack.push_data = incr_pc;
      next_state      = state;
      next_state.pc   = incr_pc;
      next_state.st   = PCS_ST_RUN;

      // Status write lands even beside a branch; the branch used the old page
      if (status_write) begin
         next_state.status = status_write_data;
      end

      if (in_flush) begin
         // Second cycle of a branch; the prefetched word is discarded
         next_state.st = PCS_ST_RUN;
      end else begin
         case (op)
            PCS_OP_JUMP: begin
               next_state.pc = jump_target;
            end
            PCS_OP_CALL: begin
               stack.push    = 1'b1;
               next_state.pc = call_target;
            end
            PCS_OP_RET: begin
               stack.pop     = 1'b1;
               next_state.pc = return_target;
            end
            PCS_OP_LOWWR: begin
               // Move, add and bit-set with the counter low byte as target
               next_state.pc = low_target;
            end
            default: begin
               next_state.pc = incr_pc;
            end
         endcase

         if (op_taken) begin
            next_state.st = PCS_ST_FLUSH;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state.pc     <= PCS_PC_RESET;
         state.status <= PCS_STATUS_RESET;
         state.st     <= PCS_ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   assign fetch_addr       = state.pc;
   assign counter_low_byte = state.pc[PCS_DATA_W-1:0];
   assign status_page_bits = state.status;
   assign flush            = in_flush;
endmodule

/* File: sim/pcs_prog_mem.sv */
`timescale 1ns/1ps
module pcs_prog_mem
   import pcs_pkg::*;
(
   input  wire logic [PCS_PC_W-1:0]   fetch_addr,
   output logic      [PCS_INSN_W-1:0] insn
);
   logic [PCS_INSN_W-1:0] mem [0:1023];
   assign insn = mem[fetch_addr];
endmodule

/* File: sim/pcs_seq_assertions.sv */
`timescale 1ns/1ps
module pcs_seq_assertions
   import pcs_pkg::*;
(
   input wire logic        clock,
   input wire logic        srst,
   input wire logic [11:0] insn,
   input wire pcs_op_t     op,
   input wire logic [7:0]  low_write_data,
   input wire logic        status_write,
   input wire logic [7:0]  status_write_data,
   input wire logic [9:0]  fetch_addr,
   input wire logic [7:0]  counter_low_byte,
   input wire logic [7:0]  status_page_bits,
   input wire logic        flush
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   logic pg;
   assign pg = status_page_bits[PCS_PAGE_BIT];
   sequence s_take(o); !flush && op == o; endsequence
   sequence s_br; !flush && op != PCS_OP_NONE; endsequence
   property p_inc; s_take(PCS_OP_NONE) |=> fetch_addr == 10'($past(fetch_addr) + 1); endproperty
   property p_jmp; s_take(PCS_OP_JUMP) |=> fetch_addr == {$past(pg), $past(insn[8:0])}; endproperty
   property p_cal; s_take(PCS_OP_CALL) |=> fetch_addr == {$past(pg), 1'b0, $past(insn[7:0])}; endproperty
   property p_low; s_take(PCS_OP_LOWWR) |=> fetch_addr == {$past(pg), 1'b0, $past(low_write_data)}; endproperty
   property p_view; counter_low_byte == fetch_addr[7:0]; endproperty
   property p_fl; s_br |=> flush ##1 !flush; endproperty
   property p_ref; flush |=> fetch_addr == 10'($past(fetch_addr) + 1); endproperty
   property p_ret; s_take(PCS_OP_CALL) ##2 s_take(PCS_OP_RET) |=>
      fetch_addr == 10'($past(fetch_addr, 3) + 1); endproperty
   property p_stat; status_write |=> status_page_bits == $past(status_write_data); endproperty
   property p_rst; disable iff (1'b0) srst |=> fetch_addr == PCS_PC_RESET && counter_low_byte == PCS_LOW_RESET &&
      status_page_bits == PCS_STATUS_RESET && !flush;
   endproperty
   a_inc: assert property (p_inc) else $error("step");
   a_jmp: assert property (p_jmp) else $error("jump");
   a_cal: assert property (p_cal) else $error("call");
   a_low: assert property (p_low) else $error("low");
   a_view: assert property (p_view) else $error("view");
   a_fl: assert property (p_fl) else $error("flush");
   a_ref: assert property (p_ref) else $error("refuse");
   a_ret: assert property (p_ret) else $error("ret");
   a_stat: assert property (p_stat) else $error("status");
   a_rst: assert property (p_rst) else $error("rst");
endmodule
bind pcs_sequencer pcs_seq_assertions u_chk (.clock, .srst, .insn, .op, .low_write_data, .status_write,
   .status_write_data, .fetch_addr, .counter_low_byte, .status_page_bits, .flush);

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import pcs_pkg::*;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic [11:0] insn;
   pcs_op_t     op = PCS_OP_NONE;
   logic [7:0]  low_write_data = 8'h3c;
   logic        status_write = 1'b0;
   logic [7:0]  status_write_data = 8'h20;
   logic [9:0]  fetch_addr;
   logic [7:0]  counter_low_byte, status_page_bits;
   logic        flush;
   int          n_fail = 0;
   int          total_checks = 0;
   initial forever #5 clock = ~clock;
   pcs_sequencer i_dut (.clock, .srst, .insn, .op, .low_write_data, .status_write, .status_write_data,
      .fetch_addr, .counter_low_byte, .status_page_bits, .flush);
   pcs_prog_mem u_mem (.fetch_addr, .insn);
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input pcs_op_t o, input logic sw = 1'b0);
      @(negedge clock);
      op = o;
      status_write = sw;
   endtask
   task automatic t_reset;
      repeat (12) @(negedge clock);
      srst = 1'b0;
      chk(fetch_addr, PCS_PC_RESET);
      chk({2'h0, counter_low_byte}, {2'h0, PCS_LOW_RESET});
      chk({2'h0, status_page_bits}, 10'h000);
      step(PCS_OP_NONE, 1'b1);
      chk(fetch_addr, 10'h000);
      step(PCS_OP_NONE);
      chk(fetch_addr, 10'h001);
      chk({2'h0, status_page_bits}, 10'h020);
      $display("reset test done");
   endtask
   task automatic t_jump;
      step(PCS_OP_JUMP);
      u_mem.mem[fetch_addr] = 12'hf55;
      step(PCS_OP_JUMP);
      chk(fetch_addr, 10'h355);
      chk({9'h000, flush}, 10'h001);
      step(PCS_OP_NONE);
      chk(fetch_addr, 10'h356);
      chk({9'h000, flush}, 10'h000);
      $display("jump test done");
   endtask
   task automatic t_call;
      logic [9:0] ret1;
      logic [9:0] ret2;
      step(PCS_OP_CALL);
      ret1 = fetch_addr + 10'h001;
      u_mem.mem[fetch_addr] = 12'h1a5;
      step(PCS_OP_NONE);
      chk(fetch_addr, 10'h2a5);
      step(PCS_OP_CALL);
      ret2 = fetch_addr + 10'h001;
      u_mem.mem[fetch_addr] = 12'h0c3;
      step(PCS_OP_NONE);
      chk(fetch_addr, 10'h2c3);
      step(PCS_OP_RET);
      step(PCS_OP_NONE);
      chk(fetch_addr, ret2);
      step(PCS_OP_RET);
      step(PCS_OP_NONE);
      chk(fetch_addr, ret1);
      $display("call test done");
   endtask
   task automatic t_low;
      status_write_data = 8'h00;
      step(PCS_OP_LOWWR, 1'b1);
      step(PCS_OP_NONE);
      chk(fetch_addr, 10'h23c);
      chk({2'h0, counter_low_byte}, 10'h03c);
      chk({2'h0, status_page_bits}, 10'h000);
      low_write_data = 8'he1;
      step(PCS_OP_LOWWR);
      step(PCS_OP_NONE);
      chk(fetch_addr, 10'h0e1);
      $display("low write test done");
   endtask
   task automatic t_rerun;
      status_write_data = 8'h20;
      step(PCS_OP_NONE, 1'b1);
      step(PCS_OP_NONE);
      chk({2'h0, status_page_bits}, 10'h020);
      srst = 1'b1;
      repeat (2) @(negedge clock);
      srst = 1'b0;
      chk(fetch_addr, PCS_PC_RESET);
      chk({2'h0, status_page_bits}, 10'h000);
      step(PCS_OP_NONE);
      chk(fetch_addr, 10'h000);
      $display("second reset test done");
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      t_reset();
      t_jump();
      t_call();
      t_low();
      t_rerun();
      stop_test();
   end
endmodule
